// file: dv/sbcs_adc_model.sv
// converter stand-in answering start pulses after a chosen latency
`timescale 1ns/1ps
module sbcs_adc_model (
    input  wire        ref_clk,
    input  wire        adcStart_r,
    input  wire        adcChannel_r,
    input  wire [7:0]  lat,
    input  wire [15:0] shVal,
    input  wire [15:0] buVal,
    output reg         adcDone,
    output reg  [15:0] adcData
);
    integer cnt = -1;
    reg     ch = 1'b0;
    initial adcDone = 1'b0;
    initial adcData = 16'h0000;
    // a restart ends the running conversion at once with an early answer,
    // which the sequencer is expected to discard
    always @(posedge ref_clk) begin
        adcDone <= 1'b0;
        adcData <= ~adcData;
        if (adcStart_r) begin
            if (cnt >= 0) begin
                adcDone <= 1'b1;
                adcData <= ch ? buVal : shVal;
            end
            cnt <= lat;
            ch <= adcChannel_r;
        end else if (cnt > 0)
            cnt <= cnt - 1;
        else if (cnt == 0) begin
            cnt <= -1;
            adcDone <= 1'b1;
            adcData <= ch ? buVal : shVal;
        end
    end
endmodule

// file: dv/sbcs_sequencer_props.sv
// port assertions for the conversion sequencer
`timescale 1ns/1ps
`include "sbcs_consts.vh"
module sbcs_sequencer_props (
    input wire        ref_clk,
    input wire        rst_n,
    input wire [7:0]  regAddr,
    input wire        regWrEn,
    input wire        regRdEn,
    input wire [15:0] regWrData,
    input wire [15:0] regRdData_r,
    input wire        adcStart_r,
    input wire        adcChannel_r,
    input wire        adcDone,
    input wire        powerDown_r,
    input wire        convReady_r
);
    localparam int WAKE_MIN = 3995;
    localparam int AWAKE = 4100;
    int wakeCnt = 0;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    // cycles since reset or power-down ended, saturating
    always @(posedge ref_clk)
        if (!rst_n || powerDown_r)
            wakeCnt <= 0;
        else if (wakeCnt <= AWAKE)
            wakeCnt <= wakeCnt + 1;
    sequence setupWr;
        regWrEn && regAddr == `SBCS_ADDR_SETUP;
    endsequence
    // no result load can land now, so a clear is not overridden
    sequence noUpd;
        !$past(adcDone) && !$past(adcDone, 2) && !$past(adcDone, 3)
            && !$past(adcDone, 4);
    endsequence
    mask_rd_clr_a: assert property (
        (regRdEn && regAddr == `SBCS_ADDR_MASK) ##0 noUpd |=> !convReady_r)
        else $error("flag kept after mask read");
    setup_clr_a: assert property (
        setupWr ##0 regWrData[1:0] != 2'b00 ##0 noUpd |=> !convReady_r)
        else $error("flag kept after setup write");
    pd_flag_kept_a: assert property (
        setupWr ##0 regWrData[1:0] == 2'b00 ##0 noUpd |=>
        powerDown_r && convReady_r == $past(convReady_r))
        else $error("power-down write mishandled");
    pd_quiet_a: assert property (
        powerDown_r |-> !adcStart_r)
        else $error("conversion during power-down");
    wake_wait_a: assert property (
        adcStart_r |-> wakeCnt >= WAKE_MIN)
        else $error("conversion before wake time");
    shot_start_a: assert property (
        setupWr ##0 regWrData[1:0] != 2'b00 ##0 wakeCnt > AWAKE |->
        ##2 adcStart_r && adcChannel_r == !$past(regWrData[0], 2))
        else $error("setup write did not start a conversion");
    rdy_after_done_a: assert property (
        $rose(convReady_r) |-> $past(adcDone, 3) || $past(adcDone, 4))
        else $error("flag without finished set");
    rd_hold_a: assert property (
        !regRdEn |=> $stable(regRdData_r))
        else $error("read data changed without a read");
endmodule
bind sbcs_sequencer sbcs_sequencer_props props (
    .ref_clk(ref_clk), .rst_n(rst_n), .regAddr(regAddr),
    .regWrEn(regWrEn), .regRdEn(regRdEn), .regWrData(regWrData),
    .regRdData_r(regRdData_r), .adcStart_r(adcStart_r),
    .adcChannel_r(adcChannel_r), .adcDone(adcDone),
    .powerDown_r(powerDown_r), .convReady_r(convReady_r)
);

// file: dv/shunt_bus_conversion_sequencer_test.sv
// self-checking bench for the shunt/bus conversion sequencer
`timescale 1ns/1ps
`include "sbcs_consts.vh"
module shunt_bus_conversion_sequencer_test;
    reg         ref_clk = 1'b0;
    reg         rst_n = 1'b0;
    reg  [7:0]  regAddr = 8'h00;
    reg         regWrEn = 1'b0;
    reg         regRdEn = 1'b0;
    reg  [15:0] regWrData = 16'h0000;
    reg  [7:0]  lat = 8'h03;
    reg  [15:0] shVal = 16'h0000;
    reg  [15:0] buVal = 16'h0000;
    reg         rdSeen = 1'b0;
    reg  [23:0] note;
    reg  [23:0] expQ[$];
    reg  [15:0] cal;
    reg  [15:0] cur;
    reg  [15:0] pwr;
    reg  [31:0] prod;
    reg  [2:0]  md;
    wire [15:0] regRdData_r;
    wire [15:0] adcData;
    wire        adcStart_r;
    wire        adcChannel_r;
    wire        adcDone;
    wire        powerDown_r;
    wire        convReady_r;
    integer     failures = 0;
    integer     nCompared = 0;
    integer     seed = 32;
    integer     nSh = 0;
    integer     nBu = 0;
    integer     i;
    integer     k;
    sbcs_sequencer uut (
        .ref_clk(ref_clk), .rst_n(rst_n), .regAddr(regAddr),
        .regWrEn(regWrEn), .regRdEn(regRdEn), .regWrData(regWrData),
        .regRdData_r(regRdData_r), .adcStart_r(adcStart_r),
        .adcChannel_r(adcChannel_r), .adcDone(adcDone), .adcData(adcData),
        .powerDown_r(powerDown_r), .convReady_r(convReady_r)
    );
    sbcs_adc_model adc (
        .ref_clk(ref_clk), .adcStart_r(adcStart_r),
        .adcChannel_r(adcChannel_r), .lat(lat), .shVal(shVal),
        .buVal(buVal), .adcDone(adcDone), .adcData(adcData)
    );
    initial forever #5 ref_clk = ~ref_clk;
    task check(input string what, input [15:0] seen, input [15:0] exp);
        nCompared = nCompared + 1;
        if (seen !== exp) begin
            failures = failures + 1;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task results;
        if (failures == 0 && nCompared > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    task wr(input [7:0] a, input [15:0] d);
        regAddr <= a;
        regWrData <= d;
        regWrEn <= 1'b1;
        @(posedge ref_clk);
        regWrEn <= 1'b0;
        @(posedge ref_clk);
    endtask
    task rd(input [7:0] a, input [15:0] e);
        regAddr <= a;
        regRdEn <= 1'b1;
        expQ.push_back({a, e});
        @(posedge ref_clk);
        regRdEn <= 1'b0;
        @(posedge ref_clk);
    endtask
    task waitRdy;
        for (i = 0; i < 9000 && convReady_r !== 1'b1; i = i + 1)
            @(posedge ref_clk);
        if (i == 9000) begin
            failures = failures + 1;
            results;
        end
    endtask
    task calc;
        prod = shVal * cal[14:0];
        cur = prod[26:11];
        prod = cur * buVal[14:0];
        pwr = prod[30:15];
    endtask
    // counts restart at every register write so a shot is counted alone
    always @(posedge ref_clk) begin
        rdSeen <= regRdEn;
        nSh <= regWrEn ? 0 : nSh + (adcStart_r && !adcChannel_r);
        nBu <= regWrEn ? 0 : nBu + (adcStart_r && adcChannel_r);
        if (rdSeen) begin
            note = expQ.pop_front();
            check($sformatf("reg%h", note[23:16]), regRdData_r,
                note[15:0]);
        end
    end
    initial begin
        repeat (10) @(posedge ref_clk);
        rst_n <= 1'b1;
        shVal <= $random(seed) & 16'h0fff;
        buVal <= $random(seed);
        @(posedge ref_clk);
        rd(`SBCS_ADDR_SETUP, `SBCS_SETUP_RST);
        rd(`SBCS_ADDR_CALIB, `SBCS_CALIB_RST);
        rd(8'h07, 16'h0000);
        wr(`SBCS_ADDR_MASK, 16'hffff);
        rd(`SBCS_ADDR_MASK, `SBCS_MASK_WMASK);
        waitRdy;
        rd(`SBCS_ADDR_BUS, buVal & 16'h7fff);
        rd(`SBCS_ADDR_SHUNT, shVal);
        rd(`SBCS_ADDR_CURRENT, 16'h0000);
        rd(`SBCS_ADDR_POWER, 16'h0000);
        cal = ($random(seed) & 16'h0fff) | 16'h0100;
        lat <= 8'd40;
        wr(`SBCS_ADDR_CALIB, cal);
        // two rounds so the checked set began after the calibration write
        repeat (2) begin
            rd(`SBCS_ADDR_MASK, `SBCS_MASK_WMASK | 16'h0008);
            waitRdy;
        end
        calc;
        shVal <= $random(seed) & 16'h0fff;
        buVal <= $random(seed);
        rd(`SBCS_ADDR_CURRENT, cur);
        rd(`SBCS_ADDR_POWER, pwr);
        wr(`SBCS_ADDR_SETUP, 16'h0400);
        check("pdown", {15'h0000, powerDown_r}, 16'h0001);
        rd(`SBCS_ADDR_MASK, `SBCS_MASK_WMASK | 16'h0008);
        cal = ($random(seed) & 16'h0fff) | 16'h0100;
        wr(`SBCS_ADDR_CALIB, cal);
        repeat (300) @(posedge ref_clk);
        check("starts", 16'(nSh + nBu), 16'h0000);
        rd(`SBCS_ADDR_CALIB, cal);
        calc;
        for (k = 0; k < 4; k = k + 1) begin
            md = (k == 3) ? 3'h3 : k[2:0] + 3'h1;
            wr(`SBCS_ADDR_SETUP, {7'h02, 6'h00, md});
            check("pdown", {15'h0000, powerDown_r}, 16'h0000);
            rd(`SBCS_ADDR_MASK, `SBCS_MASK_WMASK);
            rd(`SBCS_ADDR_SETUP, {7'h02, 6'h00, md});
            waitRdy;
            repeat (200) @(posedge ref_clk);
            check("shunts", 16'(nSh), md[0] ? 16'h0004 : 16'h0000);
            check("buses", 16'(nBu), md[1] ? 16'h0004 : 16'h0000);
        end
        rd(`SBCS_ADDR_SHUNT, shVal);
        rd(`SBCS_ADDR_BUS, buVal & 16'h7fff);
        rd(`SBCS_ADDR_CURRENT, cur);
        rd(`SBCS_ADDR_POWER, pwr);
        repeat (4) @(posedge ref_clk);
        results;
    end
endmodule

// file: src/sbcs_calc.v
// current and power multiplier used behind the conversion sequencer
`timescale 1ns/1ps
`include "sbcs_consts.vh"

module sbcs_calc (
    input  wire        clk,
    input  wire        rst_n,
    input  wire        curLoad,
    input  wire [15:0] shuntIn,
    input  wire [15:0] calIn,
    input  wire        pwrLoad,
    input  wire [15:0] busIn,
    output reg  [15:0] curOut_r,
    output reg  [15:0] pwrOut_r
);

    // calibration and bus codes are magnitudes, so the sign bit is zero
    wire signed [15:0] calPos  = {1'b0, calIn[14:0]};
    wire signed [15:0] busPos  = {1'b0, busIn[14:0]};
    wire signed [31:0] curProd = $signed(shuntIn) * calPos;
    wire signed [31:0] pwrProd = $signed(curOut_r) * busPos;
    wire               calZero = (calIn == 16'h0000);

    always @(posedge clk) begin
        if (!rst_n) begin
            curOut_r <= 16'h0000;
            pwrOut_r <= 16'h0000;
        end else begin
            if (curLoad) begin
                if (calZero) begin
                    curOut_r <= 16'h0000;
                end else begin
                    curOut_r <= curProd[`SBCS_CUR_SHIFT+15:`SBCS_CUR_SHIFT];
                end
            end
            if (pwrLoad) begin
                if (calZero) begin
                    pwrOut_r <= 16'h0000;
                end else begin
                    pwrOut_r <= pwrProd[`SBCS_PWR_SHIFT+15:`SBCS_PWR_SHIFT];
                end
            end
        end
    end

endmodule

// file: src/sbcs_consts.vh
// constants shared by the shunt/bus conversion sequencer
`ifndef SBCS_CONSTS_VH
`define SBCS_CONSTS_VH

// register map, one address per 16-bit register on the host register port
`define SBCS_ADDR_SETUP    8'h00
`define SBCS_ADDR_SHUNT    8'h01
`define SBCS_ADDR_BUS      8'h02
`define SBCS_ADDR_POWER    8'h03
`define SBCS_ADDR_CURRENT  8'h04
`define SBCS_ADDR_CALIB    8'h05
`define SBCS_ADDR_MASK     8'h06

// reset values
`define SBCS_SETUP_RST     16'h0007
`define SBCS_CALIB_RST     16'h0000
`define SBCS_MASK_RST      16'h0000

// measurement_setup fields
`define SBCS_MODE_LSB      0
`define SBCS_MODE_MSB      2
`define SBCS_AVG_LSB       9
`define SBCS_AVG_MSB       11
`define SBCS_MODE_CONT     3'h7
`define SBCS_MODE_SHOT_SH  3'h1
`define SBCS_MODE_SHOT_BUS 3'h2
`define SBCS_MODE_SHOT_ALL 3'h3

// alert_mask_and_flags fields
`define SBCS_RDY_BIT       3
`define SBCS_MASK_WMASK    16'hffe7

// adc channel select
`define SBCS_CH_SHUNT      1'b0
`define SBCS_CH_BUS        1'b1

// multiplier scaling (result bit windows)
`define SBCS_CUR_SHIFT     11
`define SBCS_PWR_SHIFT     15

// timing
`define SBCS_CLK_NS        10
`define SBCS_WAKE_NS       40000
`define SBCS_WAKE_CYC      ((`SBCS_WAKE_NS + `SBCS_CLK_NS - 1) / `SBCS_CLK_NS)

`endif

// file: src/sbcs_sequencer.v
// conversion sequencer: modes, averaging, result registers, ready flag
`timescale 1ns/1ps
`include "sbcs_consts.vh"

module sbcs_sequencer (
    input  wire        ref_clk,
    input  wire        rst_n,
    input  wire [7:0]  regAddr,
    input  wire        regWrEn,
    input  wire        regRdEn,
    input  wire [15:0] regWrData,
    output reg  [15:0] regRdData_r,
    output reg         adcStart_r,
    output reg         adcChannel_r,
    input  wire        adcDone,
    input  wire [15:0] adcData,
    output reg         powerDown_r,
    output reg         convReady_r
);

    localparam [3:0] ST_IDLE  = 4'h0;
    localparam [3:0] ST_WAKE  = 4'h1;
    localparam [3:0] ST_SHUNT = 4'h2;
    localparam [3:0] ST_WAITS = 4'h3;
    localparam [3:0] ST_BUS   = 4'h4;
    localparam [3:0] ST_WAITB = 4'h5;
    localparam [3:0] ST_PWR   = 4'h6;
    localparam [3:0] ST_ACC   = 4'h7;
    localparam [3:0] ST_UPD   = 4'h8;

    localparam [31:0] WAKE_CYC  = `SBCS_WAKE_CYC;
    localparam [11:0] WAKE_LAST = WAKE_CYC[11:0] - 12'h001;

    reg  [3:0]  state_r;
    reg  [3:0]  state_nxt;
    reg  [15:0] setupReg_r;
    reg  [15:0] calReg_r;
    reg  [15:0] maskReg_r;
    reg  [15:0] shuntRaw_r;
    reg  [15:0] busRaw_r;
    reg  [15:0] shuntRes_r;
    reg  [15:0] busRes_r;
    reg  [15:0] powerRes_r;
    reg  [15:0] currentRes_r;
    reg  [11:0] wakeCnt_r;
    reg  [7:0]  avgCnt_r;
    reg         adcBusy_r;
    reg         adcDiscard_r;

    wire [2:0]  mode      = setupReg_r[`SBCS_MODE_MSB:`SBCS_MODE_LSB];
    wire [2:0]  avgCode   = setupReg_r[`SBCS_AVG_MSB:`SBCS_AVG_LSB];
    wire [7:0]  avgLast   = (8'h01 << avgCode) - 8'h01;
    wire        cfgWr     = regWrEn && (regAddr == `SBCS_ADDR_SETUP);
    wire [2:0]  wrMode    = regWrData[`SBCS_MODE_MSB:`SBCS_MODE_LSB];
    // both shunt and bus enables low means power-down
    wire        wrPd      = (wrMode[1:0] == 2'b00);
    wire        startSeq  = cfgWr && !wrPd;
    wire        mskRd     = regRdEn && (regAddr == `SBCS_ADDR_MASK);
    // a conversion aborted by a setup write may still report; drop it
    wire        doneOk    = adcDone && !adcDiscard_r;
    wire [3:0]  firstConv = wrMode[0] ? ST_SHUNT : ST_BUS;
    wire [3:0]  againConv = mode[0] ? ST_SHUNT : ST_BUS;
    wire        curLoad   = (state_r == ST_WAITS) && doneOk;
    wire        pwrLoad   = (state_r == ST_PWR);
    wire        accClr    = cfgWr || (state_r == ST_UPD);
    wire [15:0] curCalc;
    wire [15:0] pwrCalc;

    sbcs_calc uCalc (
        .clk      (ref_clk),
        .rst_n    (rst_n),
        .curLoad  (curLoad),
        .shuntIn  (adcData),
        .calIn    (calReg_r),
        .pwrLoad  (pwrLoad),
        .busIn    (busRaw_r),
        .curOut_r (curCalc),
        .pwrOut_r (pwrCalc)
    );

    // next state of the sequence
    always @* begin
        state_nxt = state_r;
        case (state_r)
            ST_IDLE: begin
                state_nxt = ST_IDLE;
            end
            ST_WAKE: begin
                if (wakeCnt_r == WAKE_LAST) begin
                    state_nxt = againConv;
                end
            end
            ST_SHUNT: begin
                state_nxt = ST_WAITS;
            end
            ST_WAITS: begin
                if (doneOk) begin
                    state_nxt = mode[1] ? ST_BUS : ST_PWR;
                end
            end
            ST_BUS: begin
                state_nxt = ST_WAITB;
            end
            ST_WAITB: begin
                if (doneOk) begin
                    state_nxt = ST_PWR;
                end
            end
            ST_PWR: begin
                state_nxt = ST_ACC;
            end
            ST_ACC: begin
                if (avgCnt_r == avgLast) begin
                    state_nxt = ST_UPD;
                end else begin
                    state_nxt = againConv;
                end
            end
            ST_UPD: begin
                state_nxt = mode[2] ? againConv : ST_IDLE;
            end
            default: begin
                state_nxt = ST_IDLE;
            end
        endcase
        if (cfgWr) begin
            if (wrPd) begin
                state_nxt = ST_IDLE;
            end else if (powerDown_r || state_r == ST_WAKE) begin
                state_nxt = ST_WAKE;
            end else begin
                state_nxt = firstConv;
            end
        end
    end

    always @(posedge ref_clk) begin
        if (!rst_n) begin
            state_r <= ST_WAKE;
        end else begin
            state_r <= state_nxt;
        end
    end

    // wake-up timer restarts on each entry from power-down
    always @(posedge ref_clk) begin
        if (!rst_n) begin
            wakeCnt_r <= 12'h000;
        end else if (state_r != ST_WAKE) begin
            wakeCnt_r <= 12'h000;
        end else if (wakeCnt_r != WAKE_LAST) begin
            wakeCnt_r <= wakeCnt_r + 12'h001;
        end
    end

    always @(posedge ref_clk) begin
        if (!rst_n) begin
            powerDown_r <= 1'b0;
        end else if (cfgWr) begin
            powerDown_r <= wrPd;
        end
    end

    // adc request and outstanding-conversion tracking
    always @(posedge ref_clk) begin
        if (!rst_n) begin
            adcStart_r   <= 1'b0;
            adcChannel_r <= `SBCS_CH_SHUNT;
            adcBusy_r    <= 1'b0;
            adcDiscard_r <= 1'b0;
        end else begin
            adcStart_r <= 1'b0;
            if (state_r == ST_SHUNT && !cfgWr) begin
                adcStart_r   <= 1'b1;
                adcChannel_r <= `SBCS_CH_SHUNT;
            end else if (state_r == ST_BUS && !cfgWr) begin
                adcStart_r   <= 1'b1;
                adcChannel_r <= `SBCS_CH_BUS;
            end
            if (adcStart_r) begin
                adcBusy_r <= 1'b1;
            end else if (adcDone) begin
                adcBusy_r <= 1'b0;
            end
            if (cfgWr && (adcBusy_r || adcStart_r) && !adcDone) begin
                adcDiscard_r <= 1'b1;
            end else if (adcDone) begin
                adcDiscard_r <= 1'b0;
            end
        end
    end

    // raw samples for the accumulators
    always @(posedge ref_clk) begin
        if (!rst_n) begin
            shuntRaw_r <= 16'h0000;
            busRaw_r   <= 16'h0000;
        end else begin
            if (curLoad) begin
                shuntRaw_r <= adcData;
            end
            if (state_r == ST_WAITB && doneOk) begin
                busRaw_r <= {1'b0, adcData[14:0]};
            end
        end
    end

    always @(posedge ref_clk) begin
        if (!rst_n || accClr) begin
            avgCnt_r <= 8'h00;
        end else if (state_r == ST_ACC) begin
            avgCnt_r <= avgCnt_r + 8'h01;
        end
    end

    // one accumulator per quantity: shunt, bus, current, power
    wire [15:0] sample [0:3];
    wire [15:0] avgVal [0:3];
    assign sample[0] = shuntRaw_r;
    assign sample[1] = busRaw_r;
    assign sample[2] = curCalc;
    assign sample[3] = pwrCalc;

    genvar g;
    generate
        for (g = 0; g < 4; g = g + 1) begin : gAcc
            reg  [23:0]        acc_r;
            wire signed [23:0] accDiv = $signed(acc_r) >>> avgCode;
            always @(posedge ref_clk) begin
                if (!rst_n || accClr) begin
                    acc_r <= 24'h000000;
                end else if (state_r == ST_ACC) begin
                    acc_r <= acc_r + {{8{sample[g][15]}}, sample[g]};
                end
            end
            assign avgVal[g] = accDiv[15:0];
        end
    endgenerate

    // result registers change only on a finished average
    always @(posedge ref_clk) begin
        if (!rst_n) begin
            shuntRes_r   <= 16'h0000;
            busRes_r     <= 16'h0000;
            currentRes_r <= 16'h0000;
            powerRes_r   <= 16'h0000;
        end else if (state_r == ST_UPD) begin
            shuntRes_r   <= avgVal[0];
            busRes_r     <= {1'b0, avgVal[1][14:0]};
            currentRes_r <= avgVal[2];
            powerRes_r   <= avgVal[3];
        end
    end

    // ready flag: a completing average beats a clearing access
    always @(posedge ref_clk) begin
        if (!rst_n) begin
            convReady_r <= 1'b0;
        end else if (state_r == ST_UPD) begin
            convReady_r <= 1'b1;
        end else if (startSeq) begin
            convReady_r <= 1'b0;
        end else if (mskRd) begin
            convReady_r <= 1'b0;
        end
    end

    // host register writes, accepted in every mode
    always @(posedge ref_clk) begin
        if (!rst_n) begin
            setupReg_r <= `SBCS_SETUP_RST;
            calReg_r   <= `SBCS_CALIB_RST;
            maskReg_r  <= `SBCS_MASK_RST;
        end else if (regWrEn) begin
            case (regAddr)
                `SBCS_ADDR_SETUP: begin
                    setupReg_r <= regWrData;
                end
                `SBCS_ADDR_CALIB: begin
                    calReg_r <= regWrData;
                end
                `SBCS_ADDR_MASK: begin
                    maskReg_r <= regWrData & `SBCS_MASK_WMASK;
                end
                default: begin
                    maskReg_r <= maskReg_r;
                end
            endcase
        end
    end

    // read data: registered; its only side effect is that a mask read clears the ready flag
    always @(posedge ref_clk) begin
        if (!rst_n) begin
            regRdData_r <= 16'h0000;
        end else if (regRdEn) begin
            case (regAddr)
                `SBCS_ADDR_SETUP:   regRdData_r <= setupReg_r;
                `SBCS_ADDR_SHUNT:   regRdData_r <= shuntRes_r;
                `SBCS_ADDR_BUS:     regRdData_r <= busRes_r;
                `SBCS_ADDR_POWER:   regRdData_r <= powerRes_r;
                `SBCS_ADDR_CURRENT: regRdData_r <= currentRes_r;
                `SBCS_ADDR_CALIB:   regRdData_r <= calReg_r;
                `SBCS_ADDR_MASK: begin
                    regRdData_r <= maskReg_r |
                        ({15'h0000, convReady_r} << `SBCS_RDY_BIT);
                end
                default: begin
                    regRdData_r <= 16'h0000;
                end
            endcase
        end
    end

endmodule
